// File: include/afh_map.svh
`ifndef AFH_MAP_SVH
`define AFH_MAP_SVH
// ----------------------------------------------------------------------------
// Function
// RULE1: Protection faults abort synchronously and win over every other abort.
// RULE2: Protection-faulted uncached or missing access issues no bus transaction.
// RULE3: SLVERR or DECERR bus responses count as external errors causing aborts.
// RULE4: External error on instruction fetch aborts synchronously on that instruction.
// RULE5: External error on any load or store aborts asynchronously.
// RULE6: Monitor debug aborts on breakpoint, vector catch, watchpoint or soft breakpoint.
// RULE7: Synchronous abort taken on faulting instruction; asynchronous may come later.
// RULE8: Buffered writes yield to reads; late write error aborts asynchronously.
// RULE9: Asynchronous abort stays pending while mask bit set, taken when cleared.
// RULE10: Mask bit set on reset and on abort, interrupt or fast interrupt entry.
// RULE11: Only one asynchronous abort pending; later ones are dropped.
// RULE12: Barrier completion reports earlier errors, then taken or held pending.
// RULE13: Abort loads link register with return address and saves status word.
// RULE14: Abort writes type and direction into prefetch or data fault status.
// RULE15: Synchronous abort only captures address into prefetch or data fault address.
// RULE16: Correctable errors are corrected and signalled on event outputs.
// RULE17: In debug state a correctable load error sets sticky abort flag, no replay.
// RULE18: Pending asynchronous abort clears when its exception is taken.
// ----------------------------------------------------------------------------
// Response codes on the bus
`define AFH_RESP_SLVERR 2'h2
`define AFH_RESP_DECERR 2'h3
// Fault status type codes
`define AFH_FS_NONE 4'h0
`define AFH_FS_PROT 4'h1
`define AFH_FS_EXT_SYNC 4'h2
`define AFH_FS_EXT_ASYNC 4'h3
`define AFH_FS_DEBUG 4'h4
// Status word field positions
`define AFH_SW_AMASK 8
`define AFH_SW_IMASK 7
`define AFH_SW_FMASK 6
// Fault status write-direction bit
`define AFH_FS_WNR 4
// Debug status sticky synchronous abort bit
`define AFH_DBG_SYNC_ABORT 6
// Reset values
`define AFH_SW_RESET 32'h0000_01d3
`define AFH_ZERO32 32'h0000_0000
`define AFH_ZERO5 5'h00
`endif

// File: include/afh_pkg.sv
package afh_pkg;
  // Exception being entered this cycle
  typedef enum logic [2:0] {
    AFH_EX_NONE,
    AFH_EX_PREFETCH,
    AFH_EX_DATA_SYNC,
    AFH_EX_DATA_ASYNC,
    AFH_EX_DEBUG
  } afh_exc_e;
  typedef logic [31:0] afh_word_t;
endpackage : afh_pkg

// File: hw/afh_abort_unit.sv
`include "afh_map.svh"

module afh_abort_unit (
  input wire logic CLK_SYS, // Core clock, 10 MHz
  input wire logic RST_N, // Asynchronous reset, active low
  // Instruction side
  input wire logic IF_PROT_FAULT, // Protection fault on fetch
  input wire logic IF_BUS_ERR, // Fetch bus response valid with error code
  input wire logic [1:0] IF_RESP, // Fetch bus response code
  input wire logic IF_DBG_EVENT, // Breakpoint or vector catch on fetch
  input wire logic [31:0] IF_ADDR, // Fetch address
  input wire logic [31:0] IF_PC, // Instruction return address
  // Data side
  input wire logic D_REQ, // Load or store access request
  input wire logic D_WRITE, // Access is a store
  input wire logic D_TCM_HIT, // Access hits tight memory
  input wire logic D_CACHEABLE_HIT, // Access hits cache
  input wire logic D_PROT_FAULT, // Protection fault on data access
  input wire logic D_WATCH, // Watchpoint on data access
  input wire logic [31:0] D_ADDR, // Data address
  input wire logic [31:0] D_PC, // Return address of data instruction
  input wire logic D_RESP_VALID, // Load response from bus
  input wire logic [1:0] D_RESP, // Load response code
  input wire logic WB_RESP_VALID, // Buffered write response
  input wire logic [1:0] WB_RESP, // Buffered write response code
  input wire logic [31:0] ASYNC_PC, // Return address for an async take
  input wire logic SOFT_SOFT_BREAKPOINT_INSTR, // Soft breakpoint instruction executes
  input wire logic MONITOR_MODE, // Monitor-mode debug configured
  input wire logic BARRIER_REQ, // Data sync barrier executing
  input wire logic WB_EMPTY, // Write buffer drained
  input wire logic IRQ_TAKE, // Interrupt entry
  input wire logic FIQ_TAKE, // Fast interrupt entry
  input wire logic SW_WRITE, // Status word write from software
  input wire logic [31:0] SW_WDATA, // Status word write data
  input wire logic DEBUG_STATE, // Core in debug state
  input wire logic ECC_ENABLE, // Automatic correction enabled
  input wire logic ECC_CORR_ERR, // Correctable error detected
  input wire logic ECC_ON_LOAD, // Error hit a load
  output logic D_BUS_ISSUE, // Data access may go to bus
  output logic ABORT_TAKE, // Abort taken this cycle
  output logic ASYNC_PENDING, // Async abort held pending
  output logic BARRIER_DONE, // Barrier completed
  output logic LOAD_REPLAY, // Replay load with corrected data
  output logic ECC_EVENT, // Correctable error event
  output logic [31:0] current_status_word, // Status word
  output logic [31:0] abort_link_reg, // Abort link register
  output logic [31:0] abort_saved_status, // Abort saved status
  output logic [31:0] prefetch_fault_status, // Prefetch fault status
  output logic [31:0] data_fault_status, // Data fault status
  output logic [31:0] prefetch_fault_address, // Prefetch fault address
  output logic [31:0] data_fault_address, // Data fault address
  output logic [31:0] debug_status_control // Debug status
);

  // --------------------------------------------------------------------------
  // Classification
  // --------------------------------------------------------------------------
  logic if_ext_err;
  logic d_ext_err;
  logic wb_ext_err;
  logic async_evt;
  logic d_dbg;
  logic i_dbg;
  logic amask;
  logic pend_r;
  afh_pkg::afh_exc_e exc;

  // Either error code counts as an external error
  assign if_ext_err = IF_BUS_ERR && (IF_RESP == `AFH_RESP_SLVERR || IF_RESP == `AFH_RESP_DECERR); // [RULE3]
  assign d_ext_err = D_RESP_VALID && (D_RESP == `AFH_RESP_SLVERR || D_RESP == `AFH_RESP_DECERR); // [RULE3] [RULE5]
  assign wb_ext_err = WB_RESP_VALID && (WB_RESP == `AFH_RESP_SLVERR || WB_RESP == `AFH_RESP_DECERR); // [RULE8]
  assign async_evt = d_ext_err || wb_ext_err;
  assign i_dbg = MONITOR_MODE && (IF_DBG_EVENT || SOFT_SOFT_BREAKPOINT_INSTR); // [RULE6]
  assign d_dbg = MONITOR_MODE && D_REQ && D_WATCH; // [RULE6]
  assign amask = current_status_word[`AFH_SW_AMASK];

  // Priority: protection, then other synchronous, debug, then pending async
  always_comb begin
    if (D_REQ && D_PROT_FAULT) begin
      exc = afh_pkg::AFH_EX_DATA_SYNC; // [RULE1]
    end else if (IF_PROT_FAULT || if_ext_err) begin
      exc = afh_pkg::AFH_EX_PREFETCH; // [RULE1] [RULE4] [RULE7]
    end else if (i_dbg || d_dbg) begin
      exc = afh_pkg::AFH_EX_DEBUG; // [RULE6]
    end else if (pend_r && !amask) begin
      exc = afh_pkg::AFH_EX_DATA_ASYNC; // [RULE9] [RULE7]
    end else begin
      exc = afh_pkg::AFH_EX_NONE;
    end
  end

  // --------------------------------------------------------------------------
  // Pending async abort
  // --------------------------------------------------------------------------
  // A new error arriving while one is pending is dropped; the take clears
  // the pending bit, but an error in the same cycle is kept as a new one.
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      pend_r <= 1'b0;
    end else if (exc == afh_pkg::AFH_EX_DATA_ASYNC) begin
      pend_r <= async_evt; // [RULE18]
    end else if (async_evt) begin
      pend_r <= 1'b1; // [RULE5] [RULE11]
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      ASYNC_PENDING <= 1'b0;
    end else begin
      ASYNC_PENDING <= pend_r;
    end
  end

  // --------------------------------------------------------------------------
  // Bus gate and barrier
  // --------------------------------------------------------------------------
  // Faulted uncached or missing accesses never reach the bus
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      D_BUS_ISSUE <= 1'b0;
    end else begin
      D_BUS_ISSUE <= D_REQ && !D_PROT_FAULT && !D_TCM_HIT && !D_CACHEABLE_HIT; // [RULE2]
    end
  end

  // Barrier completes only once buffered writes have answered and no
  // error response arrives in that cycle, so every error is already recorded
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      BARRIER_DONE <= 1'b0;
    end else begin
      BARRIER_DONE <= BARRIER_REQ && WB_EMPTY && !async_evt; // [RULE12] [RULE8]
    end
  end

  // --------------------------------------------------------------------------
  // Status word and abort state
  // --------------------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      current_status_word <= `AFH_SW_RESET; // [RULE10]
    end else if (exc != afh_pkg::AFH_EX_NONE || IRQ_TAKE || FIQ_TAKE) begin
      current_status_word[`AFH_SW_AMASK] <= 1'b1; // [RULE10]
      if (FIQ_TAKE) begin
        current_status_word[`AFH_SW_FMASK] <= 1'b1;
      end
      current_status_word[`AFH_SW_IMASK] <= 1'b1;
    end else if (SW_WRITE) begin
      current_status_word <= SW_WDATA; // [RULE9]
    end
  end

  // Take strobe, one cycle per entry; the core redirects its fetch on it
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      ABORT_TAKE <= 1'b0;
    end else begin
      ABORT_TAKE <= exc != afh_pkg::AFH_EX_NONE; // [RULE7]
    end
  end

  // Link and saved status on every abort
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      abort_link_reg <= `AFH_ZERO32;
      abort_saved_status <= `AFH_ZERO32;
    end else begin
      if (exc != afh_pkg::AFH_EX_NONE) begin
        abort_saved_status <= current_status_word; // [RULE13]
        unique case (exc)
          afh_pkg::AFH_EX_DATA_SYNC: abort_link_reg <= D_PC; // [RULE13]
          afh_pkg::AFH_EX_DATA_ASYNC: abort_link_reg <= ASYNC_PC;
          afh_pkg::AFH_EX_DEBUG: abort_link_reg <= d_dbg ? D_PC : IF_PC;
          default: abort_link_reg <= IF_PC;
        endcase
      end
    end
  end

  // Fault status and address registers
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      prefetch_fault_status <= `AFH_ZERO32;
      data_fault_status <= `AFH_ZERO32;
      prefetch_fault_address <= `AFH_ZERO32;
      data_fault_address <= `AFH_ZERO32;
    end else begin
      unique case (exc)
        afh_pkg::AFH_EX_PREFETCH: begin
          prefetch_fault_status <= {28'h0000000,
            IF_PROT_FAULT ? `AFH_FS_PROT : `AFH_FS_EXT_SYNC}; // [RULE14]
          prefetch_fault_address <= IF_ADDR; // [RULE15]
        end
        afh_pkg::AFH_EX_DATA_SYNC: begin
          data_fault_status <= {27'h0, D_WRITE, `AFH_FS_PROT}; // [RULE14]
          data_fault_address <= D_ADDR; // [RULE15]
        end
        afh_pkg::AFH_EX_DATA_ASYNC: begin
          data_fault_status <= {28'h0000000, `AFH_FS_EXT_ASYNC}; // [RULE14]
        end
        afh_pkg::AFH_EX_DEBUG: begin
          if (d_dbg) begin
            data_fault_status <= {27'h0, D_WRITE, `AFH_FS_DEBUG}; // [RULE14]
          end else begin
            prefetch_fault_status <= {28'h0000000, `AFH_FS_DEBUG}; // [RULE14]
          end
        end
        default: begin
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Correctable errors
  // --------------------------------------------------------------------------
  // In debug state the load is not replayed; the sticky flag records it
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      ECC_EVENT <= 1'b0;
      LOAD_REPLAY <= 1'b0;
      debug_status_control <= `AFH_ZERO32;
    end else begin
      ECC_EVENT <= ECC_ENABLE && ECC_CORR_ERR; // [RULE16]
      LOAD_REPLAY <= ECC_ENABLE && ECC_CORR_ERR && ECC_ON_LOAD && !DEBUG_STATE; // [RULE17]
      if (ECC_ENABLE && ECC_CORR_ERR && ECC_ON_LOAD && DEBUG_STATE) begin
        debug_status_control[`AFH_DBG_SYNC_ABORT] <= 1'b1; // [RULE17]
      end
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  prot_gate_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // [RULE2]
    D_REQ && D_PROT_FAULT |=> !D_BUS_ISSUE)
    else $error("Faulted access issued");
  prot_prio_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // [RULE1]
    D_REQ && D_PROT_FAULT |=> ABORT_TAKE && data_fault_address == $past(D_ADDR))
    else $error("Protection fault not taken first");
  fetch_err_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // [RULE4]
    if_ext_err && !(D_REQ && D_PROT_FAULT) |=> prefetch_fault_address == $past(IF_ADDR))
    else $error("Fetch error address missed");
  mask_hold_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // [RULE9]
    pend_r && amask |=> pend_r)
    else $error("Masked async abort taken");
  mask_set_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // [RULE10]
    IRQ_TAKE || FIQ_TAKE |=> amask)
    else $error("Mask not set on entry");
  async_pend_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // [RULE5]
    async_evt && exc != afh_pkg::AFH_EX_DATA_ASYNC |=> pend_r ##1 ASYNC_PENDING)
    else $error("Async error not pending");
  pend_clear_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // [RULE18]
    exc == afh_pkg::AFH_EX_DATA_ASYNC && !async_evt |=> !pend_r)
    else $error("Pending not cleared");
  link_save_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // [RULE13]
    exc != afh_pkg::AFH_EX_NONE |=> abort_saved_status == $past(current_status_word))
    else $error("Saved status wrong");
  dbg_sticky_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // [RULE17]
    ECC_ENABLE && ECC_CORR_ERR && ECC_ON_LOAD && DEBUG_STATE |=>
      !LOAD_REPLAY && debug_status_control[`AFH_DBG_SYNC_ABORT])
    else $error("Debug load error mishandled");
  monitor_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // [RULE6]
    MONITOR_MODE && SOFT_SOFT_BREAKPOINT_INSTR |=> ABORT_TAKE)
    else $error("Soft breakpoint not aborted");

  // Classification and priority
  fetch_prot_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // [RULE1]
    IF_PROT_FAULT && !(D_REQ && D_PROT_FAULT) |=>
      ABORT_TAKE && prefetch_fault_status[3:0] == `AFH_FS_PROT)
    else $error("Fetch protection fault missed");
  bus_issue_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // [RULE2]
    D_REQ && !D_PROT_FAULT && !D_TCM_HIT && !D_CACHEABLE_HIT |=>
      D_BUS_ISSUE)
    else $error("Uncached access not issued");
  fetch_link_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // [RULE4]
    if_ext_err && !(D_REQ && D_PROT_FAULT) |=>
      ABORT_TAKE && abort_link_reg == $past(IF_PC))
    else $error("Fetch error not taken on its instruction");
  watch_take_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // [RULE6]
    MONITOR_MODE && D_REQ && D_WATCH |=>
      ABORT_TAKE)
    else $error("Watchpoint not aborted");

  // Error codes with the upper bit set are the two error responses
  load_err_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // [RULE3]
    D_RESP_VALID && D_RESP[1] && !pend_r |=>
      pend_r)
    else $error("Load error not recorded");
  write_err_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // [RULE8]
    WB_RESP_VALID && WB_RESP[1] && !pend_r |=>
      pend_r)
    else $error("Write error not recorded");

  // Entry bookkeeping
  take_mask_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // [RULE10]
    ABORT_TAKE |->
      current_status_word[`AFH_SW_AMASK])
    else $error("Mask clear after abort entry");
  sync_link_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // [RULE13]
    D_REQ && D_PROT_FAULT |=>
      abort_link_reg == $past(D_PC))
    else $error("Data abort link wrong");
  async_link_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // [RULE7]
    exc == afh_pkg::AFH_EX_DATA_ASYNC |=>
      abort_link_reg == $past(ASYNC_PC) && data_fault_status[3:0] == `AFH_FS_EXT_ASYNC)
    else $error("Async abort entry wrong");
  debug_type_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // [RULE14]
    exc == afh_pkg::AFH_EX_DEBUG && !d_dbg |=>
      prefetch_fault_status[3:0] == `AFH_FS_DEBUG)
    else $error("Debug fetch type wrong");
  // Async and debug entries carry no trustworthy address, so none is kept
  async_addr_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // [RULE15]
    exc == afh_pkg::AFH_EX_DATA_ASYNC || exc == afh_pkg::AFH_EX_DEBUG |=>
      $stable(data_fault_address) && $stable(prefetch_fault_address))
    else $error("Address captured on non-sync abort");

  // Barrier and correctable errors
  barrier_done_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // [RULE12]
    BARRIER_REQ && WB_EMPTY && !async_evt |=>
      BARRIER_DONE)
    else $error("Barrier not completed");
  barrier_wait_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // [RULE12]
    !WB_EMPTY |=>
      !BARRIER_DONE)
    else $error("Barrier done with writes buffered");
  ecc_event_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // [RULE16]
    ECC_ENABLE && ECC_CORR_ERR |=>
      ECC_EVENT)
    else $error("Correctable error not signalled");
  load_replay_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // [RULE17]
    ECC_ENABLE && ECC_CORR_ERR && ECC_ON_LOAD && !DEBUG_STATE |=>
      LOAD_REPLAY)
    else $error("Corrected load not replayed");
  async_cov: cover property (@(posedge CLK_SYS) disable iff (!RST_N)
    async_evt ##[1:20] exc == afh_pkg::AFH_EX_DATA_ASYNC);
  drop_cov: cover property (@(posedge CLK_SYS) disable iff (!RST_N)
    pend_r && async_evt && amask);
  ecc_cov: cover property (@(posedge CLK_SYS) disable iff (!RST_N) ECC_EVENT);
  fetch_cov: cover property (@(posedge CLK_SYS) disable iff (!RST_N)
    if_ext_err ##1 ABORT_TAKE);
  debug_cov: cover property (@(posedge CLK_SYS) disable iff (!RST_N)
    MONITOR_MODE && SOFT_SOFT_BREAKPOINT_INSTR ##1 ABORT_TAKE);

endmodule : afh_abort_unit

// File: verif/afh_bus_model.sv
module afh_bus_model (
  input wire logic CLK_SYS, // Core clock
  input wire logic RST_N, // Reset, active low
  input wire logic D_REQ, // Access request
  input wire logic D_WRITE, // Access is a store
  input wire logic D_BUS_ISSUE, // Access reaches the bus
  input wire logic [1:0] code, // Response the scenario commands
  input wire logic [2:0] lat, // Extra answer delay in cycles
  output logic D_RESP_VALID, // Load response
  output logic [1:0] D_RESP, // Load response code
  output logic WB_RESP_VALID, // Buffered write response
  output logic [1:0] WB_RESP // Buffered write response code
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] cnt_r;
  logic wr_r;
  // Remember the direction, then answer after the commanded delay
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      cnt_r <= 3'h0;
      wr_r <= 1'b0;
    end else begin
      if (D_REQ) wr_r <= D_WRITE;
      if (D_BUS_ISSUE) cnt_r <= lat + 3'h1;
      else if (cnt_r != 3'h0) cnt_r <= cnt_r - 3'h1;
    end
  end
  // Idle code lines show the inverse so a stale code never reads as an answer
  always_comb begin
    D_RESP_VALID = (cnt_r == 3'h1) && !wr_r;
    WB_RESP_VALID = (cnt_r == 3'h1) && wr_r;
    D_RESP = D_RESP_VALID ? code : ~code;
    WB_RESP = WB_RESP_VALID ? code : ~code;
  end
endmodule : afh_bus_model

// File: verif/abort_fault_handling_tb.sv
`include "afh_map.svh"

module abort_fault_handling_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK_SYS = 1'b0, RST_N = 1'b0, IF_PROT_FAULT = 1'b0, IF_BUS_ERR = 1'b0;
  logic IF_DBG_EVENT = 1'b0, D_REQ = 1'b0, D_WRITE = 1'b0, D_TCM_HIT = 1'b0;
  logic D_CACHEABLE_HIT = 1'b0, D_PROT_FAULT = 1'b0, D_WATCH = 1'b0, SOFT_SOFT_BREAKPOINT_INSTR = 1'b0;
  logic MONITOR_MODE = 1'b0, BARRIER_REQ = 1'b0, WB_EMPTY = 1'b0, IRQ_TAKE = 1'b0;
  logic FIQ_TAKE = 1'b0, SW_WRITE = 1'b0, DEBUG_STATE = 1'b0, ECC_ENABLE = 1'b0;
  logic ECC_CORR_ERR = 1'b0, ECC_ON_LOAD = 1'b0;
  logic [1:0] IF_RESP = 2'h1, code = 2'h0;
  logic [2:0] lat = 3'h0;
  logic [31:0] IF_ADDR = 32'h0, IF_PC = 32'h0, D_ADDR = 32'h0, D_PC = 32'h0;
  logic [31:0] ASYNC_PC = 32'h0000_8000, SW_WDATA = 32'h0;
  logic D_RESP_VALID, WB_RESP_VALID, D_BUS_ISSUE, ABORT_TAKE, ASYNC_PENDING;
  logic BARRIER_DONE, LOAD_REPLAY, ECC_EVENT;
  logic [1:0] D_RESP, WB_RESP;
  afh_pkg::afh_word_t current_status_word, abort_link_reg, abort_saved_status;
  afh_pkg::afh_word_t prefetch_fault_status, data_fault_status, prefetch_fault_address;
  afh_pkg::afh_word_t data_fault_address, debug_status_control;
  int err_count = 0, checked = 0, takes = 0, replays = 0, events = 0;

  afh_abort_unit u_afh_abort_unit (.*);
  afh_bus_model u_afh_bus_model (.*);

  // Clock at 100 ns period
  always #50 CLK_SYS = ~CLK_SYS;
  // Pulses are counted after they settle, so no one-cycle flag is missed
  always @(posedge CLK_SYS) begin
    #1;
    takes = takes + int'(ABORT_TAKE === 1'b1);
    replays = replays + int'(LOAD_REPLAY === 1'b1);
    events = events + int'(ECC_EVENT === 1'b1);
  end

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK_SYS);
  endtask : cyc
  // Bounded wait for the abort count; running out ends the run
  task automatic wait_takes(input int n);
    for (int i = 0; i < 10; i++) begin
      if (takes >= n) return;
      cyc(1);
    end
    chk(takes, n);
    wrap_up();
  endtask : wait_takes
  // One data access; a protection fault comes with a fetch error beside it
  task automatic dreq(input logic wr, input logic pf, input logic [31:0] a, input logic exp);
    cyc(1);
    D_REQ <= 1'b1;
    D_WRITE <= wr;
    D_PROT_FAULT <= pf;
    D_ADDR <= a;
    D_PC <= a + 32'h4;
    IF_BUS_ERR <= pf;
    IF_RESP <= pf ? `AFH_RESP_SLVERR : 2'h1;
    cyc(1);
    D_REQ <= 1'b0;
    D_PROT_FAULT <= 1'b0;
    IF_BUS_ERR <= 1'b0;
    IF_RESP <= 2'h1;
    #1 chk(D_BUS_ISSUE, exp);
  endtask : dreq
  task automatic clr_mask;
    cyc(1);
    SW_WRITE <= 1'b1;
    SW_WDATA <= 32'h0000_00d3;
    cyc(1);
    SW_WRITE <= 1'b0;
  endtask : clr_mask

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task automatic t_prot;
    int n;
    n = takes;
    dreq(1'b0, 1'b1, 32'h0000_1230, 1'b0);
    wait_takes(n + 1);
    chk(data_fault_status & 32'h1f, {28'h0, `AFH_FS_PROT});
    chk(data_fault_address, 32'h0000_1230);
    cyc(1);
    D_CACHEABLE_HIT <= 1'b1;
    dreq(1'b0, 1'b0, 32'h0000_1240, 1'b0);
    cyc(6);
    D_CACHEABLE_HIT <= 1'b0;
  endtask : t_prot
  task automatic t_fetch;
    int n;
    n = takes;
    cyc(1);
    IF_BUS_ERR <= 1'b1;
    IF_RESP <= `AFH_RESP_DECERR;
    IF_ADDR <= 32'h0000_3008;
    IF_PC <= 32'h0000_3008;
    cyc(1);
    IF_BUS_ERR <= 1'b0;
    IF_RESP <= 2'h0;
    wait_takes(n + 1);
    chk(prefetch_fault_status & 32'hf, {28'h0, `AFH_FS_EXT_SYNC});
    chk(prefetch_fault_address, 32'h0000_3008);
    chk(abort_link_reg, 32'h0000_3008);
    chk(abort_saved_status, `AFH_SW_RESET);
    cyc(4);
  endtask : t_fetch
  task automatic t_async;
    int n;
    n = takes;
    dreq(1'b0, 1'b0, 32'h0000_5000, 1'b1);
    cyc(5);
    chk(ASYNC_PENDING, 1'b0);
    code <= `AFH_RESP_SLVERR;
    lat <= 3'h3;
    dreq(1'b0, 1'b0, 32'h0000_5004, 1'b1);
    cyc(8);
    chk(ASYNC_PENDING, 1'b1);
    code <= `AFH_RESP_DECERR;
    lat <= 3'h0;
    dreq(1'b1, 1'b0, 32'h0000_5008, 1'b1);
    cyc(6);
    chk(takes, n);
    clr_mask();
    cyc(8);
    chk(takes, n + 1);
    chk(data_fault_status & 32'h1f, {28'h0, `AFH_FS_EXT_ASYNC});
    chk(data_fault_address, 32'h0000_1230);
    chk(abort_link_reg, ASYNC_PC);
    chk(abort_saved_status, 32'h0000_00d3);
    chk(current_status_word[`AFH_SW_AMASK], 1'b1);
    chk(ASYNC_PENDING, 1'b0);
    dreq(1'b1, 1'b0, 32'h0000_500c, 1'b1);
    cyc(6);
    chk(ASYNC_PENDING, 1'b1);
    code <= 2'h0;
  endtask : t_async
  task automatic t_barrier;
    int n;
    n = takes;
    BARRIER_REQ <= 1'b1;
    cyc(4);
    WB_EMPTY <= 1'b1;
    #1 chk(BARRIER_DONE, 1'b0);
    cyc(2);
    BARRIER_REQ <= 1'b0;
    #1 chk(BARRIER_DONE, 1'b1);
    chk(ASYNC_PENDING, 1'b1);
    clr_mask();
    wait_takes(n + 1);
  endtask : t_barrier
  task automatic t_debug;
    int n;
    logic [31:0] fs;
    MONITOR_MODE <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      n = takes;
      cyc(1);
      IF_DBG_EVENT <= (k == 0);
      D_REQ <= (k == 1);
      D_WATCH <= (k == 1);
      SOFT_SOFT_BREAKPOINT_INSTR <= (k == 2);
      cyc(1);
      {IF_DBG_EVENT, D_REQ, D_WATCH, SOFT_SOFT_BREAKPOINT_INSTR} <= 4'h0;
      wait_takes(n + 1);
      fs = (k == 1) ? data_fault_status : prefetch_fault_status;
      chk(fs & 32'hf, {28'h0, `AFH_FS_DEBUG});
      cyc(4);
    end
  endtask : t_debug
  task automatic t_mask;
    for (int k = 0; k < 2; k++) begin
      clr_mask();
      IRQ_TAKE <= (k == 0);
      FIQ_TAKE <= (k == 1);
      #1 chk(current_status_word[`AFH_SW_AMASK], 1'b0);
      cyc(1);
      {IRQ_TAKE, FIQ_TAKE} <= 2'h0;
      cyc(1);
      #1 chk(current_status_word[`AFH_SW_AMASK], 1'b1);
    end
  endtask : t_mask
  task automatic t_ecc;
    int r, e;
    r = replays;
    e = events;
    ECC_ENABLE <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      DEBUG_STATE <= (k == 1);
      cyc(1);
      {ECC_CORR_ERR, ECC_ON_LOAD} <= 2'h3;
      cyc(1);
      {ECC_CORR_ERR, ECC_ON_LOAD} <= 2'h0;
      cyc(3);
      chk(events, e + k + 1);
      chk(replays, r + 1);
    end
    chk(debug_status_control[`AFH_DBG_SYNC_ABORT], 1'b1);
  endtask : t_ecc

  // Reset, then every scenario in turn
  initial begin
    cyc(10);
    RST_N <= 1'b1;
    cyc(1);
    #1 chk(current_status_word, `AFH_SW_RESET);
    chk(data_fault_status | prefetch_fault_status, 32'h0);
    t_prot();
    t_fetch();
    t_async();
    t_barrier();
    t_debug();
    t_mask();
    t_ecc();
    wrap_up();
  end
endmodule : abort_fault_handling_tb
